//--- rtl/adc_seq_pkg.sv
package adc_seq_pkg;
    // register byte addresses
    localparam logic [11:0] ctrl1_addr   = 12'h000;
    localparam logic [11:0] ctrl2_addr   = 12'h004;
    localparam logic [11:0] seqctl_addr  = 12'h008;
    localparam logic [11:0] status_addr  = 12'h00C;
    localparam logic [11:0] dien_addr    = 12'h010;
    localparam logic [11:0] port_addr    = 12'h014;
    localparam logic [11:0] mode_addr    = 12'h018;
    // first control register fields
    localparam int trig_ch_lsb    = 0;
    localparam int trig_ch_w      = 4;
    localparam logic [3:0] trig_ch_reset = 4'hF;
    // second control register fields
    localparam int power_up_bit   = 7;
    localparam int wait_halt_bit  = 6;
    localparam int frz_msb_bit    = 5;
    localparam int frz_lsb_bit    = 4;
    localparam int level_sel_bit  = 3;
    localparam int polarity_bit   = 2;
    localparam int trig_en_bit    = 1;
    localparam int done_ie_bit    = 0;
    // sequence control / status fields
    localparam int scan_bit       = 0;
    localparam int done_bit       = 0;
    localparam int overrun_bit    = 1;
    localparam int busy_bit       = 2;
    // stop, wait and freeze mode bits
    localparam int stop_bit       = 0;
    localparam int wait_bit       = 1;
    localparam int freeze_bit     = 2;
    // conversion length in clocks; pad channel count
    localparam int seq_cycles     = 16;
    localparam int channels       = 16;
endpackage

//--- rtl/adc_trigger_sequence_control.sv
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module adc_trigger_sequence_control
    import adc_seq_pkg::*;
#(
    parameter int seq_len = seq_cycles
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pads and low power
    input  wire logic [15:0] pad_in,
    input  wire logic        stop_mode,
    input  wire logic        wait_mode,
    input  wire logic        freeze_mode,
    // converter side
    output logic      [15:0] pad_buffer_enable,
    output logic             converting,
    output logic             sequence_done_irq
);
    typedef struct packed
    {
        logic [3:0]  trig_ch;
        logic [7:0]  ctrl2;
        logic        scan;
        logic        done;
        logic        overrun;
        logic [15:0] dien;
        logic        trig_prev;
        logic        sw_start;
        logic        pending;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        irq;
    } state_type;
    state_type st;
    state_type next_st;

    sync_if #(.width(channels)) pins ();
    logic timer_busy;
    logic timer_done;
    logic start;
    logic run;
    logic abort;
    logic trig_lvl;
    logic trig_active;
    logic edge_seen;
    logic level_mode;
    logic trig_on;
    logic [15:0] port_view;
    logic setup;

    assign pins.raw = pad_in;
    pin_sync #(.width(channels)) u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (pins.snk)
    );

    seq_timer #(.cycles(seq_len)) u_timer
    (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (start),
        .run     (run),
        .abort   (abort),
        .busy    (timer_busy),
        .done    (timer_done)
    );

    always_comb
    begin
        trig_lvl    = pins.synced[st.trig_ch];
        trig_active = st.ctrl2[polarity_bit] ? trig_lvl : !trig_lvl;
        edge_seen   = trig_active && !st.trig_prev;
        level_mode  = st.ctrl2[level_sel_bit];
        trig_on     = st.ctrl2[trig_en_bit];
        abort       = !st.ctrl2[power_up_bit];
        run = !stop_mode
            && !(wait_mode && st.ctrl2[wait_halt_bit])
            && !(freeze_mode && st.ctrl2[frz_msb_bit]);
        if (trig_on)
        begin
            if (level_mode)
                start = trig_active;
            else
                start = edge_seen || st.pending;
        end
        else
            start = st.sw_start || (st.scan && st.pending);
        // soft freeze lets a running sequence finish but starts no new one
        start = start && !abort && !(freeze_mode && st.ctrl2[frz_lsb_bit]);
        port_view = pins.synced | ~st.dien;
        if (trig_on)
            port_view[st.trig_ch] = pins.synced[st.trig_ch];
        setup = psel && !penable;
    end

    always_comb
    begin
        next_st           = st;
        next_st.trig_prev = trig_active;
        next_st.ready     = 1'b0;
        next_st.slverr    = 1'b0;
        next_st.sw_start  = 1'b0;
        // continuous software mode keeps a restart pending
        if (!trig_on && st.scan && timer_done)
            next_st.pending = 1'b1;
        else if (start)
            next_st.pending = 1'b0;
        else if (trig_on && !level_mode)
            next_st.pending = 1'b0;
        if (abort)
            next_st.pending = 1'b0;
        if (trig_on && !level_mode && edge_seen && timer_busy)
            next_st.overrun = 1'b1;
        if (setup)
        begin
            next_st.ready = 1'b1;
            if (pwrite)
            begin
                case (paddr)
                    ctrl1_addr: next_st.trig_ch = pwdata[trig_ch_lsb +: trig_ch_w];
                    ctrl2_addr: next_st.ctrl2 = pwdata[7:0];
                    seqctl_addr:
                    begin
                        next_st.scan = pwdata[scan_bit];
                        next_st.done = 1'b0;
                        if (!trig_on)
                            next_st.sw_start = 1'b1;
                    end
                    status_addr:
                    begin
                        if (pwdata[overrun_bit])
                            next_st.overrun = 1'b0;
                        if (pwdata[done_bit])
                            next_st.done = 1'b0;
                    end
                    dien_addr:  next_st.dien = pwdata[15:0];
                    port_addr:  next_st.slverr = 1'b0;
                    mode_addr:  next_st.slverr = 1'b0;
                    default:    next_st.slverr = 1'b1;
                endcase
            end
            else
            begin
                case (paddr)
                    ctrl1_addr:  next_st.rdata = {28'h000_0000, st.trig_ch};
                    ctrl2_addr:  next_st.rdata = {24'h00_0000, st.ctrl2};
                    seqctl_addr: next_st.rdata = {31'h0000_0000, st.scan};
                    status_addr: next_st.rdata = {29'h0000_0000, timer_busy,
                                                  st.overrun, st.done};
                    dien_addr:   next_st.rdata = {16'h0000, st.dien};
                    port_addr:   next_st.rdata = {16'h0000, port_view};
                    mode_addr:   next_st.rdata = {29'h0000_0000, freeze_mode,
                                                  wait_mode, stop_mode};
                    default:
                    begin
                        next_st.rdata  = 32'h0000_0000;
                        next_st.slverr = 1'b1;
                    end
                endcase
            end
        end
        // hardware set wins over software clear
        if (trig_on && !level_mode && edge_seen && timer_busy)
            next_st.overrun = 1'b1;
        if (timer_done)
            next_st.done = 1'b1;
        next_st.irq = next_st.done && next_st.ctrl2[done_ie_bit];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st         <= '0;
            st.trig_ch <= trig_ch_reset;
            st.ctrl2   <= 8'h00;
        end
        else
            st <= next_st;
    end

    // outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_buffer_enable <= 16'h0000;
            converting        <= 1'b0;
        end
        else
        begin
            pad_buffer_enable <= next_st.dien;
            converting        <= (timer_busy || start) && run && !abort;
        end
    end
    assign prdata            = st.rdata;
    assign pready            = st.ready;
    assign pslverr           = st.slverr;
    assign sequence_done_irq = st.irq;
endmodule
`default_nettype wire

//--- rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(parameter int width = 16)
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pins
    sync_if.snk       port
);
    typedef struct packed
    {
        logic [width-1:0] first;
        logic [width-1:0] second;
    } state_type;
    state_type st;
    state_type next_st;
    always_comb
    begin
        next_st.first  = port.raw;
        next_st.second = st.first;
    end
    // two-stage synchroniser; first stage read only by second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end
    assign port.synced = st.second;
endmodule
`default_nettype wire

//--- rtl/seq_timer.sv
`timescale 1ns/1ps
`default_nettype none
module seq_timer #(parameter int cycles = 16)
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic start,
    input  wire logic run,
    input  wire logic abort,
    // status
    output logic      busy,
    output logic      done
);
    typedef struct packed
    {
        logic [$clog2(cycles+1)-1:0] count;
        logic                        busy;
        logic                        done;
    } state_type;
    state_type st;
    state_type next_st;
    always_comb
    begin
        next_st      = st;
        next_st.done = 1'b0;
        if (abort)
        begin
            next_st.busy  = 1'b0;
            next_st.count = '0;
        end
        else if (start && !st.busy)
        begin
            next_st.busy  = 1'b1;
            next_st.count = ($clog2(cycles+1))'(cycles - 1);
        end
        else if (st.busy && run)
        begin
            if (st.count == '0)
            begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
            else
                next_st.count = st.count - 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end
    assign busy = st.busy;
    assign done = st.done;
endmodule
`default_nettype wire

//--- rtl/sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sync_if #(parameter int width = 16);
    logic [width-1:0] raw;
    logic [width-1:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface
`default_nettype wire

//--- verif/adc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module adc_partner
(
    // clock
    input  wire logic        pclk,
    // converter side
    input  wire logic        sequence_done_irq,
    output logic      [15:0] pad_in,
    output int               irq_cycles
);
    initial
    begin
        pad_in     = 16'h0000;
        irq_cycles = 0;
    end
    // cpu counts every clock with the request high
    always @(posedge pclk)
    begin
        if (sequence_done_irq)
            irq_cycles <= irq_cycles + 1;
    end
    // pad levels held at least one clock
    task automatic drive(input logic [15:0] v);
        @(posedge pclk);
        pad_in <= v;
    endtask
endmodule
`default_nettype wire

//--- verif/adc_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_props
    import adc_seq_pkg::*;
#(
    parameter int seq_len = seq_cycles
)
(
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // modes and converter
    input wire logic        stop_mode,
    input wire logic        wait_mode,
    input wire logic        freeze_mode,
    input wire logic [15:0] pad_buffer_enable,
    input wire logic        converting,
    input wire logic        sequence_done_irq
);
    logic [7:0]  ctl;
    logic [15:0] dien;
    logic        wr;
    logic        ie;
    logic        pu;
    logic        idle;
    assign wr = psel && !penable && pwrite;
    assign ie = ctl[done_ie_bit];
    assign pu = ctl[power_up_bit];
    assign idle = !(stop_mode || wait_mode || freeze_mode);
    // shadow of written control values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl  <= 8'h00;
            dien <= 16'h0000;
        end
        else if (wr && paddr == ctrl2_addr)
            ctl  <= pwdata[7:0];
        else if (wr && paddr == dien_addr)
            dien <= pwdata[15:0];
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("no ready");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready too long");
    AST_HOLE: assert property (pready && paddr > mode_addr |-> pslverr && prdata == 32'h0000_0000)
        else $error("hole answered");
    AST_MAPPED: assert property (pready && paddr <= mode_addr |-> !pslverr)
        else $error("register refused");
    AST_IRQ_GATE: assert property (!ie && !$past(ie, 2) |-> !sequence_done_irq)
        else $error("irq not gated");
    AST_POWER_DOWN: assert property (!pu && !$past(pu) |-> !converting)
        else $error("converting unpowered");
    AST_BUF_EN: assert property (wr && paddr == dien_addr |-> ##[1:3] pad_buffer_enable == dien)
        else $error("buffer enable wrong");
    AST_SW_START: assert property (wr && paddr == seqctl_addr && pu && !ctl[trig_en_bit] && idle
        |-> ##[1:4] converting)
        else $error("no software start");
    AST_SW_BLOCKED: assert property (wr && paddr == seqctl_addr && ctl[trig_en_bit]
        && !ctl[level_sel_bit] && !converting |=> !converting [*4])
        else $error("software start with trigger");
    cover property (converting && ctl[trig_en_bit]);
    cover property (sequence_done_irq);
    cover property (pready && pslverr);
endmodule
bind adc_trigger_sequence_control adc_seq_props #(.seq_len(seq_len)) u_adc_seq_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .stop_mode, .wait_mode, .freeze_mode, .pad_buffer_enable, .converting,
    .sequence_done_irq
);
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import adc_seq_pkg::*;
;
    localparam int         sl = 8;
    localparam int         stop_recovery = 10;
    localparam logic [7:0] hc [5] = '{8'h80, 8'h80, 8'hC0, 8'hA0, 8'h90};
    localparam int         hm [5] = '{stop_bit, wait_bit, wait_bit, freeze_bit, freeze_bit};
    localparam logic [4:0] hh = 5'h0D;
    logic        pclk = 1'h0, presetn, psel, penable, pwrite;
    logic        pready, pslverr, converting, irq, err;
    logic [2:0]  lp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] pad_in, pbe;
    int          n_fail = 0, tests_run = 0, irq_cycles, c;
    always #20 pclk = ~pclk;
    adc_trigger_sequence_control #(.seq_len(sl)) u_adc_trigger_sequence_control (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pad_in, .stop_mode(lp[0]), .wait_mode(lp[1]), .freeze_mode(lp[2]),
        .pad_buffer_enable(pbe), .converting, .sequence_done_irq(irq));
    adc_partner u_adc_partner (.pclk, .sequence_done_irq(irq), .pad_in, .irq_cycles);
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'h1 && k < 16);
        n_fail += int'(k == 16);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic rchk(input string s, input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0000_0000);
        chk(s, rd, exp);
    endtask
    task automatic wconv(input logic v, input int lim);
        for (int k = 0; converting !== v && k < lim; k++)
            @(posedge pclk);
        chk("converting", converting, v);
    endtask
    // count busy cycles in a window
    task automatic hi(input int n);
        c = 0;
        repeat (n)
        begin
            @(posedge pclk);
            c += int'(converting === 1'h1);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #200us;
        n_fail++;
        print_verdict();
    end
    initial
    begin
        presetn = 1'h0;
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        lp      = 3'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rchk("ctrl1", ctrl1_addr, 32'h0000_000F);
        rchk("ctrl2", ctrl2_addr, 32'h0000_0000);
        rchk("port", port_addr, 32'h0000_FFFF);
        rchk("hole", 12'h020, 32'h0000_0000);
        chk("slverr", err, 1'h1);
        u_adc_partner.drive(16'h1234);
        apb(1'h1, dien_addr, 32'h0000_00FF);
        chk("buffer", pbe, 16'h00FF);
        rchk("port", port_addr, 32'h0000_FF34);
        $display("test pads done");
        apb(1'h1, ctrl2_addr, 32'h0000_0081);
        apb(1'h1, seqctl_addr, 32'h0000_0000);
        wconv(1'h1, 6);
        wconv(1'h0, sl + 4);
        hi(sl);
        chk("single", c, 0);
        chk("irq", irq, 1'h1);
        chk("cpu", irq_cycles > 0, 1'h1);
        rchk("status", status_addr, 32'h0000_0001);
        apb(1'h1, seqctl_addr, 32'h0000_0001);
        hi(3 * sl);
        chk("scan", c >= 3 * sl - 4, 1'h1);
        apb(1'h1, ctrl2_addr, 32'h0000_0000);
        hi(2 * sl);
        chk("abort", c <= 2, 1'h1);
        rchk("ctrl2", ctrl2_addr, 32'h0000_0000);
        $display("test software done");
        apb(1'h1, ctrl2_addr, 32'h0000_0086);
        apb(1'h1, seqctl_addr, 32'h0000_0000);
        hi(6);
        chk("blocked", c, 0);
        u_adc_partner.drive(16'h8000);
        wconv(1'h1, 5);
        u_adc_partner.drive(16'h0000);
        u_adc_partner.drive(16'h8000);
        wconv(1'h0, 2 * sl);
        rchk("overrun", status_addr, 32'h0000_0003);
        apb(1'h1, status_addr, 32'h0000_0002);
        rchk("cleared", status_addr, 32'h0000_0001);
        rchk("port", port_addr, 32'h0000_FF00);
        apb(1'h1, ctrl2_addr, 32'h0000_0082);
        u_adc_partner.drive(16'h0000);
        wconv(1'h1, 5);
        wconv(1'h0, 2 * sl);
        rchk("trig pin", port_addr, 32'h0000_7F00);
        $display("test edge done");
        apb(1'h1, ctrl2_addr, 32'h0000_008E);
        u_adc_partner.drive(16'h8000);
        wconv(1'h1, 5);
        u_adc_partner.drive(16'h0000);
        u_adc_partner.drive(16'h8000);
        hi(3 * sl);
        chk("level", c >= 3 * sl - 4, 1'h1);
        apb(1'h0, status_addr, 32'h0000_0000);
        chk("bounce", rd[overrun_bit], 1'h0);
        u_adc_partner.drive(16'h0000);
        wconv(1'h0, sl + 6);
        $display("test level done");
        for (int i = 0; i < 5; i++)
        begin
            apb(1'h1, ctrl2_addr, {24'h00_0000, hc[i]});
            apb(1'h1, seqctl_addr, 32'h0000_0000);
            wconv(1'h1, 6);
            lp[hm[i]] <= 1'h1;
            repeat (2 * sl) @(posedge pclk);
            apb(1'h0, status_addr, 32'h0000_0000);
            chk("halt", rd[busy_bit], hh[i]);
            lp <= 3'h0;
            repeat (stop_recovery) @(posedge pclk);
            wconv(1'h0, 2 * sl);
        end
        $display("test low power done");
        print_verdict();
    end
endmodule
`default_nettype wire
